// >>> core/gsr_pkg.sv
// package for the global shutter exposure and window readout block
// assumes a single 20 MHz clock; the sensor pixel stands while its read strobe is high
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package gsr_pkg;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int          PIX_W          = 8;
  localparam logic [11:0] SENSOR_COLS    = 12'h990;   // 2448 columns
  localparam logic [11:0] SENSOR_ROWS    = 12'h800;   // 2048 rows
  localparam logic [11:0] ROI_MIN_W      = 12'h008;
  localparam logic [11:0] ROI_MIN_H      = 12'h010;
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          EXP_UNIT_NS    = 1000;      // exposure time counts microseconds
  localparam int          US_CYCLES      = EXP_UNIT_NS / CLK_PERIOD_NS;
  localparam int          TARGET_MILLIFPS = 109500;   // full window frame rate goal
  localparam int          FIFO_DEPTH     = 32;

  // ----------------------------------------------------------------
  // register byte offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_EXP_TIME   = 8'h04;
  localparam logic [7:0]  REG_WIN_W      = 8'h08;
  localparam logic [7:0]  REG_WIN_H      = 8'h0c;
  localparam logic [7:0]  REG_ORG_COL    = 8'h10;
  localparam logic [7:0]  REG_ORG_ROW    = 8'h14;
  localparam logic [7:0]  REG_SENS_COLS  = 8'h18;
  localparam logic [7:0]  REG_SENS_ROWS  = 8'h1c;
  localparam logic [7:0]  REG_LIM_COLS   = 8'h20;
  localparam logic [7:0]  REG_LIM_ROWS   = 8'h24;
  localparam logic [7:0]  REG_STATUS     = 8'h28;
  localparam logic [7:0]  REG_FRAMES     = 8'h2c;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [31:0] EXP_TIME_RESET = 32'h0000_0064;
  localparam int          CTRL_ENABLE    = 0;
  localparam int          CTRL_WIDTH_MODE = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GSR_IDLE   = 2'b00,
    GSR_EXPOSE = 2'b01,
    GSR_READ   = 2'b10
  } gsr_state_t;

  typedef struct packed {
    logic             sof;   // first pixel of a frame
    logic             eol;   // last pixel of a window row
    logic             eof;   // last pixel of a frame
    logic [PIX_W-1:0] data;
  } gsr_pix_t;

  // round down to a step of eight, then clamp into [lo, hi]
  function automatic logic [11:0] gsr_fit(input logic [11:0] v, input logic [11:0] lo,
                                          input logic [11:0] hi);
    logic [11:0] r;
    r = {v[11:3], 3'h0};
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r;
  endfunction

endpackage

// >>> core/gsr_fifo.sv
// pixel FIFO between the readout sequencer and the frame grabber link
// assumes DEPTH is a power of two; output stage is a register
module gsr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,    // system clock
  input  wire logic             arst_n,   // async reset, active low
  input  wire logic             inValid,  // write request
  input  wire logic [WIDTH-1:0] inData,   // write data
  output logic                  inReady,  // room for one more in-flight word
  output logic                  outValid, // registered output holds a word
  output logic [WIDTH-1:0]      outData,  // registered output word
  input  wire logic             outReady  // consumer takes the word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             outValid_q;
  logic [WIDTH-1:0] outData_q;
  wire logic        full  = (count_q == (AW+1)'(DEPTH));
  wire logic        empty = (count_q == '0);
  wire logic        push  = inValid && !full;
  wire logic        pop   = !empty && (!outValid_q || outReady);

  // one slot kept back so a read issued now still lands next cycle
  assign inReady  = (count_q < (AW+1)'(DEPTH - 1));
  assign outValid = outValid_q;
  assign outData  = outData_q;

  // storage write, no reset needed on the array
  always_ff @(posedge clock) begin
    if (push) mem[wrPtr_q] <= inData;
  end

  // pointers and fill level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + AW'(1);
      if (pop) rdPtr_q <= rdPtr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // output register stalls while the consumer holds off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      outValid_q <= 1'b0;
      outData_q  <= '0;
    end else if (pop) begin
      outValid_q <= 1'b1;
      outData_q  <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end
endmodule // gsr_fifo

// >>> core/gsr_readout.sv
// exposure sequencer and window readout with a Wishbone classic register slave
// assumes trigIn is asynchronous; sensor pixel stands while its read strobe is high
//
// The register addresses and the Wishbone register port were chosen for this implementation.
module gsr_readout
  import gsr_pkg::*;
#(
  parameter int FIFO_DEP = gsr_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,          // 20 MHz system clock
  input  wire logic             arst_n,         // async reset, active low
  input  wire logic             cyc_i,          // wishbone cycle
  input  wire logic             stb_i,          // wishbone strobe
  input  wire logic             we_i,           // wishbone write
  input  wire logic [7:0]       adr_i,          // wishbone byte address
  input  wire logic [3:0]       sel_i,          // wishbone byte lanes
  input  wire logic [31:0]      dat_i,          // wishbone write data
  output logic [31:0]           dat_o,          // wishbone read data
  output logic                  ack_o,          // wishbone acknowledge
  input  wire logic             trigIn,         // exposure trigger pin
  output logic                  exposeAll,      // global shutter gate, all lines
  output logic                  exposureActive, // exposure-active pin
  output logic                  sensorRead,     // sensor pixel read strobe
  output logic [11:0]           sensorCol,      // sensor column of the read
  output logic [11:0]           sensorRow,      // sensor row of the read
  input  wire logic [gsr_pkg::PIX_W-1:0] sensorPix, // pixel, valid while strobe stands
  output logic                  fgValid,        // pixel toward frame grabber
  output gsr_pkg::gsr_pix_t     fgData,         // pixel with frame marks
  input  wire logic             fgReady         // frame grabber takes pixel
);
  import gsr_pkg::*;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  gsr_state_t  state_q;
  logic [1:0]  ctrl_q;
  logic [31:0] expTime_q;
  logic [11:0] roiW_q, roiH_q, orgCol_q, orgRow_q;     // software settings
  logic [11:0] winW_q, winH_q, winCol_q, winRow_q;     // frame snapshot
  logic [11:0] colIdx_q, rowIdx_q;
  logic [31:0] expUs_q;
  logic [4:0]  usDiv_q;
  logic [31:0] frames_q;
  logic        trigMeta_q, trigSync_q, trigPrev_q;
  logic        pend_q;
  gsr_pix_t    pendTag_q;
  logic        exposeAll_q, exposureActive_q, sensorRead_q, ack_q;
  logic [11:0] sensorCol_q, sensorRow_q;
  logic [31:0] dat_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // merge a write under byte lanes; shared by every writable register
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  wire logic        busReq   = cyc_i && stb_i && !ack_q;
  wire logic        busWr    = busReq && we_i;
  wire logic        trigRise = trigSync_q && !trigPrev_q;
  wire logic        trigFall = !trigSync_q && trigPrev_q;
  wire logic        widthMode = ctrl_q[CTRL_WIDTH_MODE];
  wire logic        usTick   = (usDiv_q == 5'(US_CYCLES - 1));
  wire logic        timeUp   = usTick && (expUs_q + 32'h1 >= expTime_q);
  wire logic        startExp = (state_q == GSR_IDLE) && ctrl_q[CTRL_ENABLE] && trigRise;
  wire logic        endExp   = (state_q == GSR_EXPOSE) &&
                               (widthMode ? trigFall : timeUp);
  wire logic        fifoReady;
  wire logic        issue    = (state_q == GSR_READ) && fifoReady;
  wire logic        lastCol  = (colIdx_q == winW_q - 12'h1);
  wire logic        lastRow  = (rowIdx_q == winH_q - 12'h1);
  wire logic [31:0] wrWinW   = laneMerge({20'h0, roiW_q}, dat_i, sel_i);
  wire logic [31:0] wrWinH   = laneMerge({20'h0, roiH_q}, dat_i, sel_i);
  wire logic [31:0] wrOrgC   = laneMerge({20'h0, orgCol_q}, dat_i, sel_i);
  wire logic [31:0] wrOrgR   = laneMerge({20'h0, orgRow_q}, dat_i, sel_i);
  wire logic [31:0] wrCtrl   = laneMerge({30'h0, ctrl_q}, dat_i, sel_i);

  // read mux; limits equal sensor size since nothing here bins or skips
  logic [31:0] rdMux;
  always_comb begin
    unique case (adr_i)
      REG_CTRL:      rdMux = {30'h0, ctrl_q};
      REG_EXP_TIME:  rdMux = expTime_q;
      REG_WIN_W:     rdMux = {20'h0, roiW_q};
      REG_WIN_H:     rdMux = {20'h0, roiH_q};
      REG_ORG_COL:   rdMux = {20'h0, orgCol_q};
      REG_ORG_ROW:   rdMux = {20'h0, orgRow_q};
      REG_SENS_COLS: rdMux = {20'h0, SENSOR_COLS};
      REG_SENS_ROWS: rdMux = {20'h0, SENSOR_ROWS};
      REG_LIM_COLS:  rdMux = {20'h0, SENSOR_COLS};
      REG_LIM_ROWS:  rdMux = {20'h0, SENSOR_ROWS};
      REG_STATUS:    rdMux = {29'h0, fgValid, state_q == GSR_READ, exposureActive_q};
      REG_FRAMES:    rdMux = frames_q;
      default:       rdMux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // one wait state: ack in the cycle after the request is seen
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= busReq;
      dat_q <= (busReq && !we_i) ? rdMux : 32'h0;
    end
  end

  // software registers; window size is snapped to legal steps on write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q    <= CTRL_RESET;
      expTime_q <= EXP_TIME_RESET;
      roiW_q    <= SENSOR_COLS;
      roiH_q    <= SENSOR_ROWS;
      orgCol_q  <= 12'h0;
      orgRow_q  <= 12'h0;
    end else if (busWr) begin
      unique case (adr_i)
        REG_CTRL:     ctrl_q    <= wrCtrl[1:0];
        REG_EXP_TIME: expTime_q <= laneMerge(expTime_q, dat_i, sel_i);
        REG_WIN_W:    roiW_q    <= gsr_fit(wrWinW[11:0], ROI_MIN_W, SENSOR_COLS);
        REG_WIN_H:    roiH_q    <= gsr_fit(wrWinH[11:0], ROI_MIN_H, SENSOR_ROWS);
        REG_ORG_COL:  orgCol_q  <= wrOrgC[11:0];
        REG_ORG_ROW:  orgRow_q  <= wrOrgR[11:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trigger synchroniser
  // ----------------------------------------------------------------
  // third flop only feeds edge detection, never the metastable first one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trigMeta_q <= 1'b0;
      trigSync_q <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      trigMeta_q <= trigIn;
      trigSync_q <= trigMeta_q;
      trigPrev_q <= trigSync_q;
    end
  end

  // ----------------------------------------------------------------
  // exposure sequencer
  // ----------------------------------------------------------------
  // single acquisition
  // triggers outside idle are dropped, so exposure never overlaps readout
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= GSR_IDLE;
    end else begin
      unique case (state_q)
        GSR_IDLE:   if (startExp) state_q <= GSR_EXPOSE;
        GSR_EXPOSE: if (endExp) state_q <= GSR_READ;
        GSR_READ:   if (issue && lastCol && lastRow) state_q <= GSR_IDLE;
        default:    state_q <= GSR_IDLE;
      endcase
    end
  end

  // microsecond divider restarts with each exposure for exact timing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      usDiv_q <= 5'h0;
      expUs_q <= 32'h0;
    end else if (startExp) begin
      usDiv_q <= 5'h0;
      expUs_q <= 32'h0;
    end else if (state_q == GSR_EXPOSE) begin
      usDiv_q <= usTick ? 5'h0 : usDiv_q + 5'h1;
      if (usTick) expUs_q <= expUs_q + 32'h1;
    end
  end

  // one gate for all lines: opening and closing are a single flop each way
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      exposeAll_q      <= 1'b0;
      exposureActive_q <= 1'b0;
    end else if (startExp) begin
      exposeAll_q      <= 1'b1;
      exposureActive_q <= 1'b1;
    end else if (endExp) begin
      exposeAll_q      <= 1'b0;
      exposureActive_q <= 1'b0;
    end
  end

  // window snapshot at exposure start; later writes apply to the next frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      winW_q   <= SENSOR_COLS;
      winH_q   <= SENSOR_ROWS;
      winCol_q <= 12'h0;
      winRow_q <= 12'h0;
    end else if (startExp) begin
      winW_q   <= roiW_q;
      winH_q   <= roiH_q;
      winCol_q <= orgCol_q;
      winRow_q <= orgRow_q;
    end
  end

  // ----------------------------------------------------------------
  // readout walk
  // ----------------------------------------------------------------
  // window-only walk
  // only window pixels are visited, so readout time scales with W times H
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      colIdx_q <= 12'h0;
      rowIdx_q <= 12'h0;
    end else if (startExp) begin
      colIdx_q <= 12'h0;
      rowIdx_q <= 12'h0;
    end else if (issue) begin
      colIdx_q <= lastCol ? 12'h0 : colIdx_q + 12'h1;
      if (lastCol) rowIdx_q <= rowIdx_q + 12'h1;
    end
  end

  // one pixel per clock
  // rate goal needs a clock near W*H*109.5 Hz; 20 MHz gives far less
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sensorRead_q <= 1'b0;
      sensorCol_q  <= 12'h0;
      sensorRow_q  <= 12'h0;
      pend_q       <= 1'b0;
      pendTag_q    <= '0;
    end else begin
      sensorRead_q <= issue;
      pend_q       <= issue;
      if (issue) begin
        sensorCol_q    <= winCol_q + colIdx_q;
        sensorRow_q    <= winRow_q + rowIdx_q;
        pendTag_q.sof  <= (colIdx_q == 12'h0) && (rowIdx_q == 12'h0);
        pendTag_q.eol  <= lastCol;
        pendTag_q.eof  <= lastCol && lastRow;
        pendTag_q.data <= '0;
      end
    end
  end

  // completed frames, counted when the last pixel read is issued
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) frames_q <= 32'h0;
    else if (issue && lastCol && lastRow) frames_q <= frames_q + 32'h1;
  end

  // ----------------------------------------------------------------
  // output buffer
  // ----------------------------------------------------------------
  // pixel is taken at the edge that ends its strobe and joins its frame marks
  wire gsr_pix_t pushWord = '{sof: pendTag_q.sof, eol: pendTag_q.eol,
                              eof: pendTag_q.eof, data: sensorPix};

  gsr_fifo #(
    .WIDTH ($bits(gsr_pix_t)),
    .DEPTH (FIFO_DEP)
  ) u_fifo (
    .clock    (clock),
    .arst_n   (arst_n),
    .inValid  (pend_q),
    .inData   (pushWord),
    .inReady  (fifoReady),
    .outValid (fgValid),
    .outData  (fgData),
    .outReady (fgReady)
  );

  assign dat_o          = dat_q;
  assign ack_o          = ack_q;
  assign exposeAll      = exposeAll_q;
  assign exposureActive = exposureActive_q;
  assign sensorRead     = sensorRead_q;
  assign sensorCol      = sensorCol_q;
  assign sensorRow      = sensorRow_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [23:0] pixCnt_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) pixCnt_q <= 24'h0;
    else if (startExp) pixCnt_q <= 24'h0;
    else if (issue) pixCnt_q <= pixCnt_q + 24'h1;
  end

  sequence seqOpen;
    startExp ##1 (exposeAll_q && exposureActive_q && state_q == GSR_EXPOSE);
  endsequence
  sequence seqClose;
    (!exposeAll_q && !exposureActive_q && state_q == GSR_READ);
  endsequence

  AST_EXP_OPEN: assert property (@(posedge clock) disable iff (!arst_n)
    startExp |-> seqOpen) else $error("exposure did not open on trigger");
  AST_TIMED_END: assert property (@(posedge clock) disable iff (!arst_n)
    (state_q == GSR_EXPOSE && !widthMode && timeUp) |=> seqClose)
    else $error("timed exposure did not close");
  AST_WIDTH_END: assert property (@(posedge clock) disable iff (!arst_n)
    (state_q == GSR_EXPOSE && widthMode && trigFall) |=> seqClose)
    else $error("trigger width exposure did not close");
  AST_CLOSE_TOGETHER: assert property (@(posedge clock) disable iff (!arst_n)
    exposeAll_q == exposureActive_q) else $error("gate and active pin differ");
  AST_READ_FOLLOWS: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(exposureActive_q) |-> (state_q == GSR_READ && pixCnt_q == 24'h0)
    ##[1:3] sensorRead_q) else $error("readout did not follow exposure");
  AST_NO_RETRIG: assert property (@(posedge clock) disable iff (!arst_n)
    (state_q == GSR_READ && trigRise && !(issue && lastCol && lastRow))
    |=> !exposureActive_q) else $error("trigger accepted during readout");
  AST_IN_WINDOW: assert property (@(posedge clock) disable iff (!arst_n)
    sensorRead_q |-> (sensorCol_q >= winCol_q && sensorCol_q < winCol_q + winW_q &&
                      sensorRow_q >= winRow_q && sensorRow_q < winRow_q + winH_q))
    else $error("read outside window");
  AST_FRAME_SIZE: assert property (@(posedge clock) disable iff (!arst_n)
    (state_q == GSR_READ && issue && lastCol && lastRow) |=>
    (pixCnt_q == 24'(winW_q * winH_q))) else $error("pixel count not window size");
  AST_ROI_STEP: assert property (@(posedge clock) disable iff (!arst_n)
    (roiW_q[2:0] == 3'h0 && roiH_q[2:0] == 3'h0 && roiW_q >= ROI_MIN_W &&
     roiH_q >= ROI_MIN_H)) else $error("window size off step or below minimum");
  AST_RO_LIMIT: assert property (@(posedge clock) disable iff (!arst_n)
    (busReq && !we_i && adr_i == REG_LIM_COLS) |=> (ack_q && dat_q == {20'h0, SENSOR_COLS}))
    else $error("columns limit read wrong");
endmodule // gsr_readout

// >>> tb/gsr_grabber.sv
// frame grabber stand-in: accepts pixels promptly, slowly, or not at all
// assumes the bench checks each word reported on take and word
module gsr_grabber (
  input  wire logic              clock,   // system clock
  input  wire logic              arst_n,  // async reset, active low
  input  wire logic              fgValid, // pixel offered
  input  wire gsr_pkg::gsr_pix_t fgData,  // pixel with frame marks
  input  wire logic              stall,   // hold off every transfer
  input  wire logic              slow,    // accept every other cycle
  output logic                   fgReady, // grabber accepts
  output logic                   take,    // word moves at this edge
  output gsr_pkg::gsr_pix_t      word     // the word that moves
);
  import gsr_pkg::*;
  // ready only changes after an edge; a long stall lets the pixel fifo fill up
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) fgReady <= 1'b0;
    else fgReady <= ~stall & (~slow | ~fgReady);
  // a transfer happens only where both sides agree at the edge
  assign take = fgValid & fgReady;
  assign word = fgData;
endmodule // gsr_grabber

// >>> tb/tb_global_shutter_roi_readout.sv
// self-checking bench for the exposure sequencer and window readout
// assumes a one-cycle wishbone ack and a sensor answering while its read strobe stands
module tb_global_shutter_roi_readout import gsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, arst_n, cyc, stb, we, ack, trigIn, stall, slow, take;
  logic        exposeAll, exposureActive, sensorRead, fgValid, fgReady;
  logic [7:0]  adr, sensorPix;
  logic [3:0]  sel;
  logic [11:0] sensorCol, sensorRow;
  logic [31:0] wdat, rdat, q;
  gsr_pix_t    fgData, word;
  int          error_cnt, checked, pixIdx, oc, orow, w, h, n;
  logic [7:0]  regA [9] = '{REG_WIN_W, REG_WIN_H, REG_SENS_COLS, REG_SENS_ROWS, REG_LIM_COLS,
                            REG_LIM_ROWS, 8'h30, REG_EXP_TIME, REG_STATUS};
  logic [31:0] regE [9] = '{32'h990, 32'h800, 32'h990, 32'h800, 32'h990, 32'h800, 32'h0,
                            32'h64, 32'h0};
  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  gsr_readout i_dut (.clock(clock), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .trigIn(trigIn),
    .exposeAll(exposeAll), .exposureActive(exposureActive), .sensorRead(sensorRead),
    .sensorCol(sensorCol), .sensorRow(sensorRow), .sensorPix(sensorPix), .fgValid(fgValid),
    .fgData(fgData), .fgReady(fgReady));
  gsr_grabber i_fg (.clock(clock), .arst_n(arst_n), .fgValid(fgValid), .fgData(fgData),
    .stall(stall), .slow(slow), .fgReady(fgReady), .take(take), .word(word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle; the request stands until ack is seen at an edge
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, wr, a, d, 4'hf};
    do begin
      @(posedge clock);
      k++;
    end while (ack !== 1'b1 && k < 50);
    // a missing acknowledge counts as a mismatch
    if (ack !== 1'b1) chk(32'(ack), 32'h1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // expected pixel k of the window: row-major, marks at row and frame ends
  function automatic gsr_pix_t pexp(input int k);
    logic [11:0] c, r;
    c = 12'(oc + k % w);
    r = 12'(orow + k / w);
    return {k == 0, k % w == w - 1, k == w * h - 1, c[7:0] ^ {r[4:0], 3'h0}};
  endfunction
  // sensor answers while the strobe stands; off a read it shows the inverse, so skew shows
  assign sensorPix = sensorRead ? (sensorCol[7:0] ^ {sensorRow[4:0], 3'h0})
                                : ~(sensorCol[7:0] ^ {sensorRow[4:0], 3'h0});
  always @(posedge clock) begin
    chk(32'(exposeAll), 32'(exposureActive));
    if (take === 1'b1) begin
      chk(32'(word), 32'(pexp(pixIdx)));
      pixIdx++;
    end
  end
  task automatic frame(input logic [1:0] mode, input int hold, input int lo, input int hi);
    int k;
    pixIdx = 0;
    wb(1'b1, REG_CTRL, {30'h0, mode});
    trigIn <= 1'b1;
    k = 0;
    while (exposureActive !== 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    n = 0;
    while (exposureActive === 1'b1 && n < 5000) begin
      @(posedge clock);
      n++;
      if (n == hold) trigIn <= 1'b0;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
    @(posedge clock);
    chk({sensorRead, sensorCol, sensorRow}, {1'b1, 12'(oc), 12'(orow)});
    // a second trigger in mid-readout must not open a new exposure
    trigIn <= 1'b1;
    k = 0;
    while (pixIdx < w * h && k < 3000) begin
      @(posedge clock);
      k++;
      if (k == 8) trigIn <= 1'b0;
      if (k == 150) stall <= 1'b0;
      if (exposureActive === 1'b1) chk(32'h1, 32'h0);
    end
    chk(pixIdx, w * h);
    $display("frame test done, %0d pixels", pixIdx);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, cyc, stb, we, adr, wdat, sel, trigIn, stall, slow} = '0;
    {oc, orow, w, h} = {32'd3, 32'd5, 32'd16, 32'd16};
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    foreach (regA[i]) rd(regA[i], regE[i]);
    wb(1'b1, REG_LIM_COLS, 32'h10);
    rd(REG_LIM_COLS, 32'h990);
    wb(1'b1, REG_WIN_W, 32'hd);
    rd(REG_WIN_W, 32'h8);
    wb(1'b1, REG_WIN_H, 32'h5);
    rd(REG_WIN_H, 32'h10);
    wb(1'b1, REG_WIN_H, 32'h10);
    wb(1'b1, REG_WIN_W, 32'h10);
    wb(1'b1, REG_ORG_COL, 32'h3);
    wb(1'b1, REG_ORG_ROW, 32'h5);
    wb(1'b1, REG_EXP_TIME, 32'h2);
    // a trigger while the block is disabled must not open exposure
    trigIn <= 1'b1;
    repeat (8) @(posedge clock);
    chk(32'(exposureActive), 32'h0);
    trigIn <= 1'b0;
    repeat (4) @(posedge clock);
    $display("register test done");
    stall <= 1'b1;
    frame(2'h1, 5, 40, 40);
    rd(REG_FRAMES, 32'h1);
    wb(1'b1, REG_WIN_W, 32'h8);
    wb(1'b1, REG_ORG_COL, 32'h0);
    {oc, orow, w} = {32'd0, 32'd5, 32'd8};
    slow <= 1'b1;
    frame(2'h3, 60, 64, 64);
    rd(REG_FRAMES, 32'h2);
    test_done;
  end
  // two short frames and some bus traffic need well under this span
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    test_done;
  end
endmodule // tb_global_shutter_roi_readout
